// ### common/csi_pkg.sv
// shared constants and types for the clock generator serial configuration port
`default_nettype none
package csi_pkg;

  // ==========================================================
  // register map
  localparam int         CSI_NUM_REGS      = 16;
  localparam int         CSI_FIFO_DEPTH    = 32;
  localparam logic [7:0] CSI_CTRL_REG      = 8'h00;
  localparam int         CSI_ADDR_SEL_LSB  = 5;
  localparam logic [7:0] CSI_REG_RESET     = 8'h00;
  localparam logic [7:0] CSI_DEV_ADDR_BASE = 8'hd0;
  localparam logic [3:0] CSI_BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // types
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] data;
  } csi_wr_t;

  typedef enum {CSI_IDLE, CSI_DEV, CSI_REG, CSI_WR, CSI_ACK, CSI_RD, CSI_RACK, CSI_RNEXT}
    csi_link_t;

  typedef enum {CSI_CM_IDLE, CSI_CM_DRAIN, CSI_CM_APPLY} csi_commit_t;

  // ==========================================================
  // helpers
  function automatic logic [7:0] csi_dev_addr(input logic [1:0] sel);
    csi_dev_addr = CSI_DEV_ADDR_BASE | {5'h00, sel, 1'b0};
  endfunction

endpackage
`default_nettype wire

// ### hdl/csi_fifo.sv
// write buffer fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module csi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room available
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // pop request
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_idx;
  logic [AW-1:0]    next_rd_idx;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // depth must be a power of two so the indices wrap by themselves
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
    next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
    next_count  = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count  <= next_count;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_idx] <= in_data;
  end
endmodule
`default_nettype wire

// ### hdl/csi_slave.sv
// two-wire serial slave holding the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module csi_slave #(
  parameter int NUM_REGS   = csi_pkg::CSI_NUM_REGS,
  parameter int FIFO_DEPTH = csi_pkg::CSI_FIFO_DEPTH
) (
  input  wire logic                     sys_clk,             // 100 MHz system clock
  input  wire logic                     rst,                 // async reset, high
  input  wire logic                     serial_clock_pin,    // bus clock from master
  input  wire logic                     serial_data_pin_in,  // bus data level
  output logic                          serial_data_pin_out, // driven level, always low
  output logic                          serial_data_pin_oe,  // high pulls data low
  output logic [NUM_REGS-1:0][7:0]      cfg_regs,            // committed registers
  output logic                          busy                 // transfer in progress
);
  import csi_pkg::*;

  localparam int IW = $clog2(NUM_REGS);

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [7:0] a);
    in_range = 32'(a) < NUM_REGS;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [NUM_REGS-1:0][7:0] r,
                                         input logic [7:0] a);
    rd_byte = in_range(a) ? r[a[IW-1:0]] : 8'h00;
  endfunction

  // ==========================================================
  // pin synchronisers and bus condition detect
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3} <= {serial_clock_pin, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {serial_data_pin_in, sda_s1, sda_s2};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s2 && !scl_s3;
  assign scl_fall  = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // ==========================================================
  // link engine
  csi_link_t   st;
  csi_link_t   after;
  logic [3:0]  cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [7:0]  ptr;
  logic        sda_oe;
  csi_link_t   next_st;
  csi_link_t   next_after;
  logic [3:0]  next_cnt;
  logic [7:0]  next_shreg;
  logic [7:0]  next_tx;
  logic [7:0]  next_ptr;
  logic        next_sda_oe;
  logic        push;
  logic        push_ready;
  logic        fifo_in_ready;
  logic [7:0]  own_addr;
  logic [NUM_REGS-1:0][7:0] regs;
  csi_commit_t cm;

  assign own_addr   = csi_dev_addr(regs[CSI_CTRL_REG[IW-1:0]][CSI_ADDR_SEL_LSB +: 2]);
  assign push_ready = fifo_in_ready && (cm == CSI_CM_IDLE);

  always_comb
  begin
    next_st     = st;
    next_after  = after;
    next_cnt    = cnt;
    next_shreg  = shreg;
    next_tx     = tx;
    next_ptr    = ptr;
    next_sda_oe = sda_oe;
    push        = 1'b0;
    if (start_det)
    begin
      // also the repeated start of a sequential read
      next_st     = CSI_DEV;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_det)
    begin
      next_st     = CSI_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (st)
        CSI_DEV, CSI_REG, CSI_WR:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s2};
            next_cnt   = cnt + 4'h1;
          end
          else if (scl_fall && cnt == CSI_BITS_PER_BYTE)
          begin
            next_cnt    = 4'h0;
            next_st     = CSI_ACK;
            next_sda_oe = 1'b1;
            if (st == CSI_DEV)
            begin
              if (shreg[7:1] == own_addr[7:1])
                next_after = shreg[0] ? CSI_RD : CSI_REG;
              else
              begin
                next_st     = CSI_IDLE;
                next_sda_oe = 1'b0;
              end
            end
            else if (st == CSI_REG)
            begin
              next_ptr   = shreg;
              next_after = CSI_WR;
            end
            else
            begin
              push = 1'b1;
              if (push_ready)
              begin
                next_ptr   = ptr + 8'h01;
                next_after = CSI_WR;
              end
              else
              begin
                // buffer full: refuse the byte rather than lose it
                next_st     = CSI_IDLE;
                next_sda_oe = 1'b0;
              end
            end
          end
        end
        CSI_ACK:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_st     = after;
            next_cnt    = 4'h0;
            if (after == CSI_RD)
            begin
              next_tx     = rd_byte(regs, ptr);
              next_sda_oe = !next_tx[7];
            end
          end
        end
        CSI_RD:
        begin
          if (scl_rise)
            next_cnt = cnt + 4'h1;
          else if (scl_fall)
          begin
            if (cnt == CSI_BITS_PER_BYTE)
            begin
              next_sda_oe = 1'b0;
              next_st     = CSI_RACK;
              next_ptr    = ptr + 8'h01;
            end
            else
            begin
              next_tx     = {tx[6:0], 1'b0};
              next_sda_oe = !tx[6];
            end
          end
        end
        CSI_RACK:
        begin
          if (scl_rise)
            next_st = sda_s2 ? CSI_IDLE : CSI_RNEXT;
        end
        CSI_RNEXT:
        begin
          if (scl_fall)
          begin
            next_tx     = rd_byte(regs, ptr);
            next_sda_oe = !next_tx[7];
            next_cnt    = 4'h0;
            next_st     = CSI_RD;
          end
        end
        default:
        begin
          next_st     = CSI_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st                  <= CSI_IDLE;
      after               <= CSI_IDLE;
      cnt                 <= 4'h0;
      shreg               <= 8'h00;
      tx                  <= 8'h00;
      ptr                 <= 8'h00;
      sda_oe              <= 1'b0;
      busy                <= 1'b0;
      serial_data_pin_out <= 1'b0;
    end
    else
    begin
      st                  <= next_st;
      after               <= next_after;
      cnt                 <= next_cnt;
      shreg               <= next_shreg;
      tx                  <= next_tx;
      ptr                 <= next_ptr;
      sda_oe              <= next_sda_oe;
      busy                <= next_st != CSI_IDLE;
      serial_data_pin_out <= 1'b0;
    end
  end

  assign serial_data_pin_oe = sda_oe;

  // ==========================================================
  // write buffer and commit at stop
  csi_wr_t fifo_out;
  logic    fifo_out_valid;
  logic    pop;

  csi_fifo #(
    .WIDTH ($bits(csi_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push && (cm == CSI_CM_IDLE)),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr, shreg}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  logic [NUM_REGS-1:0][7:0] shadow;
  logic [NUM_REGS-1:0][7:0] next_shadow;
  logic [NUM_REGS-1:0][7:0] next_regs;
  csi_commit_t              next_cm;

  // bytes land in a shadow copy first so the bank changes in one edge
  always_comb
  begin
    next_cm     = cm;
    next_shadow = shadow;
    next_regs   = regs;
    pop         = 1'b0;
    case (cm)
      CSI_CM_IDLE:
      begin
        if (stop_det)
        begin
          next_shadow = regs;
          next_cm     = CSI_CM_DRAIN;
        end
      end
      CSI_CM_DRAIN:
      begin
        pop = 1'b1;
        if (fifo_out_valid)
        begin
          if (in_range(fifo_out.addr))
            next_shadow[fifo_out.addr[IW-1:0]] = fifo_out.data;
        end
        else
          next_cm = CSI_CM_APPLY;
      end
      CSI_CM_APPLY:
      begin
        next_regs = shadow;
        next_cm   = CSI_CM_IDLE;
      end
      default: next_cm = CSI_CM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cm     <= CSI_CM_IDLE;
      shadow <= {NUM_REGS{CSI_REG_RESET}};
      regs   <= {NUM_REGS{CSI_REG_RESET}};
    end
    else
    begin
      cm     <= next_cm;
      shadow <= next_shadow;
      regs   <= next_regs;
    end
  end

  assign cfg_regs = regs;
endmodule
`default_nettype wire

// ### verif/csi_master.sv
// bus master model for the two-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module csi_master (
  input  wire logic sys_clk, // system clock
  input  wire logic sda,     // resolved data wire
  output logic      scl,     // bus clock, still between frames
  output logic      sda_oe   // high pulls data low
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // =====
  // bit timing: 80 ns period, data moves early in the low phase
  task automatic bit_io(input logic b, output logic s);
    @(posedge sys_clk) sda_oe <= ~b;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b1;
    @(posedge sys_clk) s = sda;
    repeat (2) @(posedge sys_clk);
    scl <= 1'b0;
  endtask

  // long settle so a slave ack is gone before clock rises
  task automatic start_cond();
    @(posedge sys_clk) sda_oe <= 1'b0;
    repeat (6) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_oe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    @(posedge sys_clk) sda_oe <= 1'b1;
    repeat (6) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_oe <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

// ### verif/csi_slave_chk.sv
// port assertions for the configuration slave
`timescale 1ns/1ps
`default_nettype none
module csi_slave_chk #(
  parameter int NUM_REGS   = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                     sys_clk,             // clock
  input wire logic                     rst,                 // reset
  input wire logic                     serial_clock_pin,    // bus clock
  input wire logic                     serial_data_pin_in,  // bus data
  input wire logic                     serial_data_pin_out, // driven level
  input wire logic                     serial_data_pin_oe,  // pull enable
  input wire logic [NUM_REGS-1:0][7:0] cfg_regs,            // bank
  input wire logic                     busy                 // engine busy
);
  logic       scl_d;
  logic       sda_d;
  logic [3:0] fall_cnt;
  logic [6:0] stop_cnt;
  logic       start_seen;
  logic       stop_seen;

  assign start_seen = scl_d && serial_clock_pin && sda_d && !serial_data_pin_in;
  assign stop_seen  = scl_d && serial_clock_pin && !sda_d && serial_data_pin_in;

  // =====
  // cycles since the last clock fall and the last stop, saturating
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      fall_cnt <= 4'hf;
      stop_cnt <= 7'h7f;
    end
    else
    begin
      scl_d <= serial_clock_pin;
      sda_d <= serial_data_pin_in;
      fall_cnt <= (scl_d && !serial_clock_pin) ? 4'h1 : fall_cnt + {3'h0, fall_cnt != 4'hf};
      stop_cnt <= stop_seen ? 7'h00 : stop_cnt + {6'h00, stop_cnt != 7'h7f};
    end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence ack_held_s;
    serial_data_pin_oe [*6];
  endsequence

  // =====
  // assertions
  out_low_a: assert property (!serial_data_pin_out)
    else $error("data pin driven high");
  idle_quiet_a: assert property (!busy && !$past(busy) |-> !serial_data_pin_oe)
    else $error("data pulled while idle");
  oe_edge_a: assert property ($changed(serial_data_pin_oe) |-> fall_cnt inside {[1:6]})
    else $error("data changed away from clock fall");
  oe_held_a: assert property ($rose(serial_data_pin_oe) |-> !serial_clock_pin ##0 ack_held_s)
    else $error("pull not held for the bit");
  commit_idle_a: assert property ($changed(cfg_regs) |-> !busy)
    else $error("bank changed during transfer");
  // one drain cycle per buffered entry, plus sync lag and the apply edge
  commit_stop_a: assert property ($changed(cfg_regs) |-> 32'(stop_cnt) <= FIFO_DEPTH + 13)
    else $error("bank changed away from stop");
  start_busy_a: assert property (start_seen |-> ##[1:6] busy)
    else $error("start not taken");
  stop_idle_a: assert property (stop_seen |-> ##[1:6] !busy)
    else $error("stop did not end transfer");
endmodule

bind csi_slave csi_slave_chk #(
  .NUM_REGS   (NUM_REGS),
  .FIFO_DEPTH (FIFO_DEPTH)
) chk (
  .sys_clk             (sys_clk),
  .rst                 (rst),
  .serial_clock_pin    (serial_clock_pin),
  .serial_data_pin_in  (serial_data_pin_in),
  .serial_data_pin_out (serial_data_pin_out),
  .serial_data_pin_oe  (serial_data_pin_oe),
  .cfg_regs            (cfg_regs),
  .busy                (busy)
);
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the configuration slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csi_pkg::*;
  logic                         sys_clk;
  logic                         rst;
  logic                         dut_out;
  logic                         dut_oe;
  logic                         scl;
  logic                         m_oe;
  logic [CSI_NUM_REGS-1:0][7:0] regs;
  logic                         busy;
  wire logic                    sda;
  int                           err_count;
  int                           cmp_count;

  // open drain with pull-up
  assign sda = ~(m_oe | (dut_oe & ~dut_out));

  csi_master host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

  csi_slave #(.NUM_REGS(CSI_NUM_REGS), .FIFO_DEPTH(CSI_FIFO_DEPTH)) dut (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .serial_clock_pin    (scl),
    .serial_data_pin_in  (sda),
    .serial_data_pin_out (dut_out),
    .serial_data_pin_oe  (dut_oe),
    .cfg_regs            (regs),
    .busy                (busy)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // =====
  // helpers
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic probe(input logic [7:0] dev, input logic exp);
    logic a;
    host.start_cond();
    host.put_byte(dev, a);
    check("addr ack", {7'h00, a}, {7'h00, exp});
    host.stop_cond();
  endtask

  task automatic address(input logic [7:0] dev, input logic [7:0] ptr);
    logic a;
    host.start_cond();
    host.put_byte(dev, a);
    check("dev ack", {7'h00, a}, 8'h01);
    host.put_byte(ptr, a);
    check("reg ack", {7'h00, a}, 8'h01);
  endtask

  // =====
  // scenarios
  task automatic t_write_block();
    logic a;
    address(8'hd0, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      host.put_byte(8'(8'h11 * (i + 1)), a);
      check("data ack", {7'h00, a}, 8'h01);
    end
    check("held", regs[2], 8'h00);
    host.stop_cond();
    repeat (50) @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
      check("written", regs[2+i], 8'(8'h11 * (i + 1)));
  endtask

  task automatic t_seq_read();
    logic       a;
    logic [7:0] d;
    address(8'hd0, 8'h02);
    host.start_cond();
    host.put_byte(8'hd1, a);
    check("rd ack", {7'h00, a}, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      host.get_byte(i == 1, d);
      check("seq rd", d, 8'(8'h11 * (i + 1)));
    end
    host.stop_cond();
    host.start_cond();
    host.put_byte(8'hd1, a);
    host.get_byte(1'b1, d);
    check("cur rd", d, 8'h33);
    host.stop_cond();
  endtask

  // stalls the commit until stop; the 33rd byte finds the buffer full
  task automatic t_fill();
    logic       a;
    logic [7:0] d;
    address(8'hd0, 8'h08);
    for (int i = 0; i <= CSI_FIFO_DEPTH; i++)
    begin
      host.put_byte(8'(8'h80 + i), a);
      check("fill ack", {7'h00, a}, {7'h00, i < CSI_FIFO_DEPTH});
    end
    host.stop_cond();
    repeat (60) @(posedge sys_clk);
    for (int i = 8; i < CSI_NUM_REGS; i++)
      check("drained", regs[i], 8'(8'h78 + i));
    // msb-high first bit, then a read past the end of the bank
    address(8'hd0, 8'h0f);
    host.start_cond();
    host.put_byte(8'hd1, a);
    check("top rd ack", {7'h00, a}, 8'h01);
    host.get_byte(1'b0, d);
    check("top rd", d, 8'h87);
    host.get_byte(1'b1, d);
    check("oor rd", d, 8'h00);
    host.stop_cond();
  endtask

  task automatic t_addr_sel();
    logic       a;
    logic [7:0] cur;
    cur = 8'hd0;
    for (int s = 1; s < 4; s++)
    begin
      address(cur, 8'h00);
      host.put_byte(8'(s << 5), a);
      check("sel ack", {7'h00, a}, 8'h01);
      host.stop_cond();
      repeat (50) @(posedge sys_clk);
      probe(cur, 1'b0);
      cur = 8'(8'hd0 + 2 * s);
      probe(cur, 1'b1);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    err_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_write_block();
    t_seq_read();
    t_fill();
    t_addr_sel();
    finish_test();
  end
endmodule
`default_nettype wire
